// [hw/fdsif_buf2.sv]
`timescale 1ns/1ps
`default_nettype none
// two-entry buffer; in_ready falls only when both slots hold data
module fdsif_buf2 import fdsif_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire fdsif_rd_s in_data,
	output logic out_valid,
	input wire logic out_ready,
	output fdsif_rd_s out_data
);
	fdsif_rd_s mem_q [2];
	logic wp_q;
	logic rp_q;
	logic [1:0] cnt_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = (cnt_q != 2'd2);
	assign out_valid = (cnt_q != 2'd0);
	assign out_data = mem_q[rp_q];
	// pointers and fill count
	always_ff @(posedge clk) begin
		if (rst) begin
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			cnt_q <= 2'd0;
		end else begin
			if (push) begin
				mem_q[wp_q] <= in_data;
				wp_q <= ~wp_q;
			end
			if (pop)
				rp_q <= ~rp_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // fdsif_buf2
`default_nettype wire

// [hw/fdsif_map.svh]
`ifndef FDSIF_MAP_SVH
`define FDSIF_MAP_SVH
// crystal rate in kHz and write-gate lead time in ns
`define FDSIF_CLK_KHZ 20000
`define FDSIF_XTAL_KHZ 6000
`define FDSIF_WG_LEAD_NS 1000
// least lead rounds up to whole cycles
`define FDSIF_WG_LEAD_CYC ((`FDSIF_WG_LEAD_NS * `FDSIF_CLK_KHZ + 999999) / 1000000)
// half-bit-cell clock half period in CLK cycles (single/double density)
`define FDSIF_HB_HALF_SD 8'h14
`define FDSIF_HB_HALF_DD 8'h0A
// read word length: clock and data bits of one byte cell
`define FDSIF_RD_BITS 16
`endif

// [hw/fdsif_pkg.sv]
package fdsif_pkg;
	// write request from controller core
	typedef struct packed {
		logic [7:0] data;
		logic low_current;
	} fdsif_wr_s;
	// one recovered cell word: clock bits in upper byte, data bits in lower byte
	typedef struct packed {
		logic [7:0] clk_bits;
		logic [7:0] data_bits;
	} fdsif_rd_s;
	typedef enum logic [1:0] {
		FDSIF_IDLE,
		FDSIF_LEAD,
		FDSIF_SHIFT,
		FDSIF_TAIL
	} fdsif_wst_e;
endpackage

// [hw/fdsif_top.sv]
// Functional notes
// (RULE_01) low track-zero input means head at track zero
// (RULE_02) drive pulses index low once per revolution
// (RULE_03) each low sector-hole transition marks one sector
// (RULE_04) refuse writes while write protect is low
// (RULE_05) inverted write stream on shared output while gating
// (RULE_06) shared output low when reading, else high
// (RULE_07) write gate leads data by one microsecond
// (RULE_08) host may request low write current
// (RULE_09) density output high double, low single
// (RULE_10) read stream interleaves clock and data bits
// (RULE_11) sample read data on strobe rising edge
// (RULE_12) separator keeps read strobe running and locked
// (RULE_13) half-bit-cell clock at twice transfer rate
// (RULE_14) timing derives from one reference clock
// (RULE_15) direction while stepping, side select afterwards
// (RULE_16) synchronise drive status inputs before use
`timescale 1ns/1ps
`default_nettype none
`include "fdsif_map.svh"
module fdsif_top import fdsif_pkg::*; (
	// controller clock and reset
	input wire logic CLK,
	input wire logic RST,
	// drive status pins
	input wire logic TRACK_ZERO_N,
	input wire logic INDEX_N,
	input wire logic SECTOR_N,
	input wire logic WRITE_PROTECT_N,
	// core status out
	output logic AT_TRACK_ZERO,
	output logic INDEX_PULSE,
	output logic SECTOR_PULSE,
	output logic PROTECTED,
	// core write request
	input wire logic WR_VALID,
	output logic WR_READY,
	input wire fdsif_wr_s WR_REQ,
	input wire logic WR_LAST,
	output logic WR_REFUSED,
	output logic WR_BUSY,
	// core mode controls
	input wire logic DOUBLE_DENSITY,
	input wire logic READ_ACTIVE,
	input wire logic STEPPING,
	input wire logic STEP_INWARD,
	input wire logic SIDE_SEL,
	// drive and separator pins
	output logic WRITE_GATE_N,
	output logic WRITE_DATA_OR_SEPARATOR_RESET,
	output logic LOW_CURRENT_OR_DENSITY,
	output logic DIR_OR_SIDE,
	output logic HALF_BIT_CELL_CLOCK,
	// read link, on separator strobe clock
	input wire logic READ_STROBE_N,
	input wire logic RST_LINK,
	input wire logic READ_DATA,
	// recovered words to core
	output logic RD_VALID,
	input wire logic RD_READY,
	output fdsif_rd_s RD_WORD,
	output logic RD_STROBE_TICK
);
	localparam int LEAD = `FDSIF_WG_LEAD_CYC;

	// two-stage synchronisers on the drive pins
	logic [3:0] s1_q, s2_q, s3_q;
	always_ff @(posedge CLK) begin
		if (RST) begin
			s1_q <= 4'hF;
			s2_q <= 4'hF;
			s3_q <= 4'hF;
		end else begin
			s1_q <= {TRACK_ZERO_N, INDEX_N, SECTOR_N, WRITE_PROTECT_N}; // RULE_16
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	wire idx_fall = s3_q[2] && !s2_q[2]; // RULE_02
	wire sec_fall = s3_q[1] && !s2_q[1]; // RULE_03

	// status outputs registered
	always_ff @(posedge CLK) begin
		if (RST) begin
			AT_TRACK_ZERO <= 1'b0;
			INDEX_PULSE <= 1'b0;
			SECTOR_PULSE <= 1'b0;
			PROTECTED <= 1'b0;
		end else begin
			AT_TRACK_ZERO <= !s2_q[3]; // RULE_01
			INDEX_PULSE <= idx_fall;
			SECTOR_PULSE <= sec_fall;
			PROTECTED <= !s2_q[0];
		end
	end

	// write serialiser state
	fdsif_wst_e st_q, st_d;
	logic [7:0] sh_q;
	logic [2:0] bit_q;
	logic [7:0] cnt_q;
	logic [7:0] hb_q;
	logic hb_tick_q;
	logic bitclk_q;
	logic lc_q;
	logic last_q;
	logic ser_q;

	// half-bit-cell clock: bit cell is two half cells, so divider drives output
	wire [7:0] hb_half = DOUBLE_DENSITY ? `FDSIF_HB_HALF_DD : `FDSIF_HB_HALF_SD;
	wire hb_wrap = (hb_q >= hb_half - 8'd1);
	always_ff @(posedge CLK) begin
		if (RST) begin
			hb_q <= 8'h00;
			HALF_BIT_CELL_CLOCK <= 1'b0;
			bitclk_q <= 1'b0;
			hb_tick_q <= 1'b0;
		end else begin
			hb_q <= hb_wrap ? 8'h00 : hb_q + 8'd1;
			if (hb_wrap)
				HALF_BIT_CELL_CLOCK <= ~HALF_BIT_CELL_CLOCK; // RULE_13 RULE_14
			if (hb_wrap)
				bitclk_q <= bitclk_q ^ HALF_BIT_CELL_CLOCK;
			// one tick per bit cell: every second fall of the half-cell clock
			hb_tick_q <= hb_wrap && HALF_BIT_CELL_CLOCK && bitclk_q; // RULE_13
		end
	end

	// write request acceptance; protected media refused
	// same registered level as the status output, so refusal and status agree
	wire protect = PROTECTED;
	wire take_first = (st_q == FDSIF_IDLE) && WR_VALID && !protect; // RULE_04
	wire take_next = (st_q == FDSIF_SHIFT) && hb_tick_q && (bit_q == 3'd7) && !last_q;
	wire lead_done = (st_q == FDSIF_LEAD) && (cnt_q >= LEAD[7:0]) && hb_tick_q;
	assign WR_READY = take_first || (take_next && WR_VALID);

	// next-state selection
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			FDSIF_IDLE: if (take_first) st_d = FDSIF_LEAD;
			FDSIF_LEAD: if (lead_done) st_d = FDSIF_SHIFT; // RULE_07
			FDSIF_SHIFT: if (hb_tick_q && bit_q == 3'd7 && (last_q || !WR_VALID))
				st_d = FDSIF_TAIL;
			FDSIF_TAIL: if (hb_tick_q) st_d = FDSIF_IDLE; // RULE_07
		endcase
	end

	// serialiser registers
	always_ff @(posedge CLK) begin
		if (RST) begin
			st_q <= FDSIF_IDLE;
			sh_q <= 8'h00;
			bit_q <= 3'd0;
			cnt_q <= 8'h00;
			lc_q <= 1'b0;
			last_q <= 1'b0;
			ser_q <= 1'b0;
			WR_REFUSED <= 1'b0;
		end else begin
			st_q <= st_d;
			WR_REFUSED <= (st_q == FDSIF_IDLE) && WR_VALID && protect; // RULE_04
			if (st_q == FDSIF_LEAD)
				cnt_q <= (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'd1;
			else
				cnt_q <= 8'h00;
			if (take_first || (take_next && WR_VALID)) begin
				sh_q <= WR_REQ.data;
				lc_q <= WR_REQ.low_current; // RULE_08
				last_q <= WR_LAST;
			end
			if (st_q == FDSIF_SHIFT && hb_tick_q) begin
				ser_q <= sh_q[7];
				if (!(take_next && WR_VALID))
					sh_q <= {sh_q[6:0], 1'b0};
				bit_q <= bit_q + 3'd1;
			end else if (st_q != FDSIF_SHIFT) begin
				bit_q <= 3'd0;
				// last bit stands through the tail cell, else it would be cut short
				if (st_q != FDSIF_TAIL)
					ser_q <= 1'b0;
			end
		end
	end

	// drive pins: gate, shared data/reset, current/density, dir/side
	wire gating = (st_q != FDSIF_IDLE);
	always_ff @(posedge CLK) begin
		if (RST) begin
			WRITE_GATE_N <= 1'b1;
			WRITE_DATA_OR_SEPARATOR_RESET <= 1'b1;
			LOW_CURRENT_OR_DENSITY <= 1'b0;
			DIR_OR_SIDE <= 1'b0;
			WR_BUSY <= 1'b0;
		end else begin
			WRITE_GATE_N <= !gating; // RULE_07
			WR_BUSY <= gating;
			if (gating)
				WRITE_DATA_OR_SEPARATOR_RESET <= !ser_q; // RULE_05
			else
				WRITE_DATA_OR_SEPARATOR_RESET <= !READ_ACTIVE; // RULE_06
			if (gating)
				LOW_CURRENT_OR_DENSITY <= lc_q; // RULE_08
			else
				LOW_CURRENT_OR_DENSITY <= DOUBLE_DENSITY; // RULE_09
			DIR_OR_SIDE <= STEPPING ? STEP_INWARD : SIDE_SEL; // RULE_15
		end
	end

	// link domain: shift on strobe rising edge
	logic [15:0] rsh_q;
	logic [3:0] rcnt_q;
	fdsif_rd_s rword_q;
	logic rtog_q;
	logic stog_q;
	always_ff @(posedge READ_STROBE_N) begin
		if (RST_LINK) begin
			rsh_q <= 16'h0000;
			rcnt_q <= 4'h0;
			rword_q <= '0;
			rtog_q <= 1'b0;
			stog_q <= 1'b0;
		end else begin
			rsh_q <= {rsh_q[14:0], READ_DATA}; // RULE_11 RULE_10
			rcnt_q <= rcnt_q + 4'h1;
			stog_q <= ~stog_q; // RULE_12
			if (rcnt_q == 4'hF) begin
				rword_q.clk_bits <= {rsh_q[14], rsh_q[12], rsh_q[10], rsh_q[8],
					rsh_q[6], rsh_q[4], rsh_q[2], rsh_q[0]}; // RULE_10
				rword_q.data_bits <= {rsh_q[13], rsh_q[11], rsh_q[9], rsh_q[7],
					rsh_q[5], rsh_q[3], rsh_q[1], READ_DATA};
				rtog_q <= ~rtog_q;
			end
		end
	end

	// toggle crossing; word stays stable a full word time after its toggle
	logic [2:0] wt_q, st3_q;
	always_ff @(posedge CLK) begin
		if (RST) begin
			wt_q <= 3'b000;
			st3_q <= 3'b000;
			RD_STROBE_TICK <= 1'b0;
		end else begin
			wt_q <= {wt_q[1:0], rtog_q};
			st3_q <= {st3_q[1:0], stog_q};
			RD_STROBE_TICK <= st3_q[2] ^ st3_q[1]; // RULE_12
		end
	end
	wire word_evt = wt_q[2] ^ wt_q[1];

	// buffer toward the core; a full buffer drops the word, the link cannot stall
	logic b_valid;
	fdsif_rd_s b_data;
	wire b_ready_out = !RD_VALID || RD_READY;
	fdsif_buf2 u_buf (
		.clk(CLK),
		.rst(RST),
		.in_valid(word_evt),
		.in_ready(),
		.in_data(rword_q),
		.out_valid(b_valid),
		.out_ready(b_ready_out),
		.out_data(b_data)
	);
	// output stage register keeps outputs on flip-flops
	always_ff @(posedge CLK) begin
		if (RST) begin
			RD_VALID <= 1'b0;
			RD_WORD <= '0;
		end else if (b_ready_out) begin
			RD_VALID <= b_valid;
			if (b_valid)
				RD_WORD <= b_data; // empty slots never reach the word
		end
	end
endmodule // fdsif_top
`default_nettype wire

// [testbench/fdsif_drv.sv]
`timescale 1ns/1ps
`default_nettype none
// spinning drive and separator; strobe never stops so the link stays locked
module fdsif_drv (
	// bench controls
	input wire logic spin,
	input wire logic hold,
	input wire logic [15:0] word,
	// pins
	output logic index_n,
	output logic sector_n,
	output logic read_strobe_n,
	output logic rst_link,
	output logic read_data
);
	logic [7:0] ang_q = 8'h88;
	logic [3:0] bit_q = 4'h0;
	assign index_n = !(ang_q < 8'h10);
	assign sector_n = !(ang_q[4:0] < 5'h08);
	initial begin
		read_strobe_n = 1'b1;
		rst_link = 1'b1;
		forever #6 read_strobe_n = !read_strobe_n;
	end
	// bit set up half a period before the sampling edge
	always @(negedge read_strobe_n) begin
		read_data <= word[4'hF - (rst_link ? 4'h0 : bit_q)];
		bit_q <= rst_link ? 4'h1 : bit_q + 4'h1;
		rst_link <= hold;
		ang_q <= ang_q + {7'h00, spin};
	end
endmodule // fdsif_drv
`default_nettype wire

// [testbench/fdsif_props.sv]
`timescale 1ns/1ps
`default_nettype none
module fdsif_props (
	// clock, reset
	input wire logic CLK,
	input wire logic RST,
	// status
	input wire logic TRACK_ZERO_N,
	input wire logic WRITE_PROTECT_N,
	input wire logic AT_TRACK_ZERO,
	input wire logic PROTECTED,
	input wire logic INDEX_PULSE,
	// write and pins
	input wire logic WR_VALID,
	input wire logic WR_READY,
	input wire logic WR_REFUSED,
	input wire logic READ_ACTIVE,
	input wire logic DOUBLE_DENSITY,
	input wire logic WRITE_GATE_N,
	input wire logic WRITE_DATA_OR_SEPARATOR_RESET,
	input wire logic LOW_CURRENT_OR_DENSITY
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// two idle edges: registered pins have left write mode
	sequence idle2;
		WRITE_GATE_N ##1 WRITE_GATE_N;
	endsequence
	// first byte of a write only: gate still high when it is taken
	sequence take;
		WR_VALID && WR_READY && WRITE_GATE_N;
	endsequence
	// gate low, shared output still idle high
	sequence quiet8;
		(!WRITE_GATE_N && WRITE_DATA_OR_SEPARATOR_RESET) [*8];
	endsequence
	tz_level_a: assert property ($stable(TRACK_ZERO_N) [*5] |-> AT_TRACK_ZERO == !TRACK_ZERO_N)
		else $error("bad track zero");
	wp_level_a: assert property ($stable(WRITE_PROTECT_N) [*5] |-> PROTECTED == !WRITE_PROTECT_N)
		else $error("bad protect");
	idx_once_a: assert property (INDEX_PULSE |=> !INDEX_PULSE)
		else $error("long index pulse");
	wp_refuse_a: assert property (WR_VALID && PROTECTED && WRITE_GATE_N |-> !WR_READY ##1 WR_REFUSED && WRITE_GATE_N)
		else $error("protected write taken");
	gate_lead_a: assert property (take |-> ##2 quiet8 ##1 quiet8 ##1 quiet8)
		else $error("gate late");
	read_low_a: assert property (idle2 ##0 $past(READ_ACTIVE) |-> !WRITE_DATA_OR_SEPARATOR_RESET)
		else $error("reset not low");
	idle_high_a: assert property (idle2 ##0 !$past(READ_ACTIVE) |-> WRITE_DATA_OR_SEPARATOR_RESET)
		else $error("reset not high");
	dens_sel_a: assert property (idle2 |-> LOW_CURRENT_OR_DENSITY == $past(DOUBLE_DENSITY))
		else $error("bad density");
endmodule // fdsif_props
bind fdsif_top fdsif_props fdsif_props_i (.*);
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fdsif_map.svh"
module tb_top import fdsif_pkg::*; ;
	// named as the ports so that .* connects them
	logic CLK, RST, TRACK_ZERO_N, INDEX_N, SECTOR_N, WRITE_PROTECT_N, AT_TRACK_ZERO;
	logic INDEX_PULSE, SECTOR_PULSE, PROTECTED, WR_VALID, WR_READY, WR_LAST, WR_REFUSED;
	logic WR_BUSY, DOUBLE_DENSITY, READ_ACTIVE, STEPPING, STEP_INWARD, SIDE_SEL;
	logic WRITE_GATE_N, WRITE_DATA_OR_SEPARATOR_RESET, LOW_CURRENT_OR_DENSITY, DIR_OR_SIDE;
	logic HALF_BIT_CELL_CLOCK, READ_STROBE_N, RST_LINK, READ_DATA, RD_VALID, RD_READY;
	logic RD_STROBE_TICK, spin, hold, e, v;
	logic [15:0] word;
	fdsif_wr_s WR_REQ;
	fdsif_rd_s RD_WORD;
	int n_mismatch, comparisons, cyc, n_idx, n_sec, n_ip, n_sp, n, lows;
	fdsif_top fdsif_top_i (.*);
	fdsif_drv fdsif_drv_i (.spin(spin), .hold(hold), .word(word), .index_n(INDEX_N),
		.sector_n(SECTOR_N), .read_strobe_n(READ_STROBE_N), .rst_link(RST_LINK),
		.read_data(READ_DATA));
	initial begin
		CLK = 1'b0;
		forever #25 CLK = !CLK;
	end
	// pin falls against core pulses; cycle ceiling
	always @(negedge INDEX_N) n_idx++;
	always @(negedge SECTOR_N) n_sec++;
	always @(posedge CLK) begin
		n_ip += INDEX_PULSE;
		n_sp += SECTOR_PULSE;
		if (++cyc == 20000) begin
			n_mismatch++;
			conclude();
		end
	end
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic tick();
		@(posedge CLK);
		#1;
	endtask
	// stream order is clock, data, clock...; word holds them apart
	function automatic logic [15:0] split(logic [15:0] s);
		for (int j = 0; j < 8; j++) begin
			split[15 - j] = s[15 - 2 * j];
			split[7 - j] = s[14 - 2 * j];
		end
	endfunction
	// one byte, or two in one stream; second byte offered until ready is seen
	task automatic wr(logic [7:0] d, logic [7:0] d2, logic lc, logic two);
		WR_REQ = '{data: d, low_current: lc};
		WR_LAST = !two;
		WR_VALID = 1'b1;
		tick();
		WR_REQ = '{data: d2, low_current: lc};
		WR_LAST = 1'b1;
		WR_VALID = two;
		// gate register follows the accepting edge by one cycle
		tick();
		check("busy", WR_BUSY, 1);
		n = 0;
		lows = 0;
		repeat (2000) begin
			if (WRITE_GATE_N !== 1'b0) break;
			n++;
			lows += !WRITE_DATA_OR_SEPARATOR_RESET;
			e = LOW_CURRENT_OR_DENSITY;
			v = WR_READY;
			tick();
			if (v) WR_VALID = 1'b0;
		end
		check("idle", WR_BUSY, 0);
		check("gate", 16'(n >= `FDSIF_WG_LEAD_CYC + (two ? 64 : 32) * `FDSIF_HB_HALF_DD), 1);
		check("ones", 16'((lows + 2 * `FDSIF_HB_HALF_DD) / (4 * `FDSIF_HB_HALF_DD)),
			16'($countones(d) + (two ? $countones(d2) : 0)));
		check("low current", e, lc);
	endtask
	task automatic rd(logic [15:0] w);
		hold = 1'b1;
		RD_READY = 1'b1;
		repeat (12) tick();
		word = w;
		hold = 1'b0;
		n = 0;
		repeat (400) begin
			RD_READY = 1'($urandom);
			if (RD_VALID === 1'b1 && RD_READY) n++;
			if (RD_VALID === 1'b1 && RD_READY) check("word", RD_WORD, split(w));
			tick();
		end
		check("words", 16'(n > 0), 1);
	endtask
	initial begin
		void'($urandom(92));
		{RST, hold, DOUBLE_DENSITY, TRACK_ZERO_N, WRITE_PROTECT_N, WR_LAST} = '1;
		{WR_VALID, RD_READY, READ_ACTIVE, STEPPING, STEP_INWARD, SIDE_SEL, spin} = '0;
		WR_REQ = '0;
		word = 16'h0000;
		repeat (5) tick();
		RST = 1'b0;
		for (int i = 0; i < 4; i++) begin
			{WRITE_PROTECT_N, TRACK_ZERO_N} = ~i[1:0];
			repeat (6) tick();
			check("track zero", AT_TRACK_ZERO, i[0]);
			check("protect", PROTECTED, i[1]);
		end
		WR_VALID = 1'b1;
		tick();
		WR_VALID = 1'b0;
		check("refused", WR_REFUSED, 1);
		WRITE_PROTECT_N = 1'b1;
		repeat (40) begin
			{READ_ACTIVE, STEPPING, STEP_INWARD, SIDE_SEL, DOUBLE_DENSITY} = 5'($urandom);
			e = STEPPING ? STEP_INWARD : SIDE_SEL;
			tick();
			check("dir side", DIR_OR_SIDE, e);
		end
		// half period per density
		for (int i = 0; i < 2; i++) begin
			DOUBLE_DENSITY = i[0];
			repeat (60) tick();
			v = HALF_BIT_CELL_CLOCK;
			repeat (50) if (HALF_BIT_CELL_CLOCK === v) tick();
			v = HALF_BIT_CELL_CLOCK;
			for (n = 0; n < 50 && HALF_BIT_CELL_CLOCK === v; n++) tick();
			check("half cell", 16'(n), i ? `FDSIF_HB_HALF_DD : `FDSIF_HB_HALF_SD);
		end
		READ_ACTIVE = 1'b0;
		wr(8'h00, 8'h00, 1'b1, 1'b0);
		wr(8'hFF, 8'h00, 1'b0, 1'b0);
		wr(8'($urandom), 8'($urandom), 1'($urandom), 1'b1);
		spin = 1'b1;
		rd(16'hAAAA);
		rd(16'($urandom));
		spin = 1'b0;
		repeat (10) tick();
		check("index", 16'(n_ip), 16'(n_idx));
		check("sector", 16'(n_sp), 16'(n_sec));
		conclude();
	end
endmodule // tb_top
`default_nettype wire
